// ---- design/gpf_clk_nco.v ----
`default_nettype none

`include "gpf_defines.vh"

// ----------------------------------------------------------------
// fixed clock output from a phase accumulator
// ----------------------------------------------------------------
module gpf_clk_nco (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire run_i,
  output reg clk_o
);

  localparam [25:0] STEP = `GPF_NCO_STEP;
  localparam [25:0] MODV = `GPF_NCO_MOD;

  reg [25:0] acc_ff; // phase accumulator
  wire [25:0] sum;
  wire wrap;

  assign sum = acc_ff + STEP;
  assign wrap = (sum >= MODV);

  // toggles twice per period; edges jitter
  // one cycle, 25 MHz is no multiple
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      acc_ff <= 26'h0000000;
      clk_o <= 1'b0;
    end else if (run_i) begin
      acc_ff <= wrap ? (sum - MODV) : sum;
      if (wrap) begin
        clk_o <= ~clk_o;
      end
    end
  end

endmodule // gpf_clk_nco

`default_nettype wire

// ---- design/gpf_defines.vh ----
`ifndef GPF_DEFINES_VH
`define GPF_DEFINES_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define GPF_FUNC0_ADDR 32'hFFFF0D00
`define GPF_FUNC1_ADDR 32'hFFFF0D04
`define GPF_FUNC2_ADDR 32'hFFFF0D08
`define GPF_DAT0_ADDR 32'hFFFF0D20
`define GPF_PORT_STRIDE 32'h00000010
`define GPF_DAT_OFS 32'h00000000
`define GPF_SET_OFS 32'h00000004
`define GPF_CLR_OFS 32'h00000008

// ----------------------------------------------------------------
// reset values and writable masks of the function registers
// ----------------------------------------------------------------
`define GPF_FUNC0_RST 32'h11100000
`define GPF_FUNC1_RST 32'h10000000
`define GPF_FUNC2_RST 32'h01000000
`define GPF_FUNC0_MASK 32'h11111111
`define GPF_FUNC1_MASK 32'h10000011
`define GPF_FUNC2_MASK 32'h01110000

// ----------------------------------------------------------------
// function select bit positions
// ----------------------------------------------------------------
`define GPF_F0_SS 0
`define GPF_F0_SCLK 4
`define GPF_F0_MISO 8
`define GPF_F0_MOSI 12
`define GPF_F0_FIXED_CLOCK_OUTPUT 16
`define GPF_F0_HVA 20
`define GPF_F0_HVB 24
`define GPF_F1_RXD 0
`define GPF_F1_TXD 4
`define GPF_F2_DIAG_RD 16
`define GPF_F2_DIAG_WR 20
`define GPF_F2_STI 24

// ----------------------------------------------------------------
// port bit masks and direction-and-value field positions
// ----------------------------------------------------------------
`define GPF_P0_MASK 8'h7F
`define GPF_P1_MASK 8'h03
`define GPF_P2_MASK 8'h73
`define GPF_DIR_LSB 16
`define GPF_OUT_LSB 8
`define GPF_IN_LSB 0

// ----------------------------------------------------------------
// clock rates and fixed clock output synthesis
// ----------------------------------------------------------------
`define GPF_CLK_FREQ_HZ 25000000
`define GPF_FIXED_CLOCK_OUTPUT_FREQ_HZ 2560000
`define GPF_NCO_STEP (2 * `GPF_FIXED_CLOCK_OUTPUT_FREQ_HZ)
`define GPF_NCO_MOD `GPF_CLK_FREQ_HZ

`endif

// ---- design/gpf_in_sync.v ----
`default_nettype none

// ----------------------------------------------------------------
// three-stage input synchroniser with agreement filter
// ----------------------------------------------------------------
module gpf_in_sync #(
  parameter W = 12
) (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);

  reg [W-1:0] s1_ff; // metastable stage, read only by s2
  reg [W-1:0] s2_ff; // second stage
  reg [W-1:0] s3_ff; // third stage
  wire [W-1:0] nxt_sync;

  // a bit moves only once stages two and three agree
  assign nxt_sync = (s2_ff & s3_ff) | (sync_o & (s2_ff ^ s3_ff));

  // shift chain, pull-up level at reset
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s1_ff <= {W{1'b1}};
      s2_ff <= {W{1'b1}};
      s3_ff <= {W{1'b1}};
      sync_o <= {W{1'b1}};
    end else begin
      s1_ff <= async_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      sync_o <= nxt_sync;
    end
  end

endmodule // gpf_in_sync

`default_nettype wire

// ---- design/gpf_top.v ----
// What this block does
// - nine pins in ports of five, two, two
// - all pins plain GPIO after reset
// - level high interrupts on pins 0,5,7,8
// - four registers per port
// - pins hold their level in power-down
// - function bit 0 routes SPI select
// - function bit 4 routes SPI clock
// - function bit 8 routes SPI MISO
// - function bit 12 routes SPI MOSI
// - function bit 16 outputs 2.56 MHz clock
// - bit 20 enables internal line five
// - bit 24 enables internal line six
// - function register 32 bits, resets 0x11100000
// - lines five, six form internal link
// - port two bits four, five diagnostic
// - port two bit six GPIO or test data
`default_nettype none

`include "gpf_defines.vh"

module gpf_top (
  input wire ref_clk_i,
  input wire rst_n_i,
  // ahb-lite slave
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output reg hreadyout_o,
  output reg hresp_o,
  // external pins
  input wire [8:0] gpio_in_i,
  output reg [8:0] gpio_out_o,
  output reg [8:0] gpio_oe_n_o,
  // internal high-voltage link lines
  input wire hv_link_line_a_i,
  output reg hv_link_line_a_o,
  output reg hv_link_line_a_oe_n_o,
  input wire hv_link_line_b_i,
  output reg hv_link_line_b_o,
  output reg hv_link_line_b_oe_n_o,
  // internal diagnostic and test lines
  input wire diag_readback_line_i,
  output reg diag_write_line_o,
  output reg test_data_out_line_o,
  // peripheral side
  input wire [3:0] spi_out_i,
  input wire [3:0] spi_oe_n_i,
  output reg [3:0] spi_in_o,
  input wire uart_txd_i,
  output reg uart_rxd_o,
  input wire lin_txd_i,
  output reg lin_rxd_o,
  input wire serial_test_data_i,
  input wire power_down_i,
  output reg [3:0] ext_irq_o
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  reg [31:0] func0_ff; // port0_function_select
  reg [31:0] func1_ff; // port 1 port_function_control
  reg [31:0] func2_ff; // port 2 port_function_control
  reg [7:0] dir_ff [0:2]; // direction per port, 1 = output
  reg [7:0] out_ff [0:2]; // output value per port
  reg wr_pend_ff; // write data phase pending
  reg [31:0] wr_addr_ff; // address of pending write

  reg [31:0] nxt_func0;
  reg [31:0] nxt_func1;
  reg [31:0] nxt_func2;
  reg [7:0] nxt_dir [0:2];
  reg [7:0] nxt_out [0:2];
  reg [31:0] rd_val; // read answer from next-state view
  reg [7:0] in_val [0:2]; // input readback per port

  wire [11:0] pin_q; // synchronised pin levels
  wire fixed_clock_output; // synthesised fixed clock
  wire addr_ok; // address phase taken
  integer p;
  integer q; // flop loop index

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // implemented bits of each port
  function [7:0] port_mask;
    input [1:0] idx;
    begin
      case (idx)
        2'h0: port_mask = `GPF_P0_MASK;
        2'h1: port_mask = `GPF_P1_MASK;
        2'h2: port_mask = `GPF_P2_MASK;
        default: port_mask = 8'h00;
      endcase
    end
  endfunction

  // byte address of a per-port register
  function [31:0] port_addr;
    input [1:0] idx;
    input [31:0] ofs;
    begin
      port_addr = `GPF_DAT0_ADDR + (`GPF_PORT_STRIDE * {30'h0, idx}) + ofs;
    end
  endfunction

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  gpf_in_sync #(
    .W(12)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({diag_readback_line_i, hv_link_line_b_i, hv_link_line_a_i,
              gpio_in_i}),
    .sync_o(pin_q)
  );

  // ----------------------------------------------------------------
  // fixed clock output source
  // ----------------------------------------------------------------
  // frozen in power-down so the pin keeps its level
  gpf_clk_nco u_nco (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(func0_ff[`GPF_F0_FIXED_CLOCK_OUTPUT] & ~power_down_i),
    .clk_o(fixed_clock_output)
  );

  // ----------------------------------------------------------------
  // input readback per port
  // ----------------------------------------------------------------
  // output-only internal lines read back their driven value
  always @* begin
    in_val[0] = {1'b0, pin_q[10], pin_q[9], pin_q[4:0]};
    in_val[1] = {6'h00, pin_q[6:5]};
    in_val[2] = {1'b0, test_data_out_line_o, diag_write_line_o,
                 pin_q[11], 2'h0, pin_q[8:7]};
  end

  // ----------------------------------------------------------------
  // register next state and read answer
  // ----------------------------------------------------------------
  assign addr_ok = hsel_i & htrans_i[1] & hready_i;

  // writes land in the data phase; reads are answered from the
  // next-state view so a read right after a write sees it
  always @* begin
    nxt_func0 = func0_ff;
    nxt_func1 = func1_ff;
    nxt_func2 = func2_ff;
    for (p = 0; p < 3; p = p + 1) begin
      nxt_dir[p] = dir_ff[p];
      nxt_out[p] = out_ff[p];
    end
    if (wr_pend_ff) begin
      // reserved bits are not stored and read as zero
      if (wr_addr_ff == `GPF_FUNC0_ADDR) begin
        nxt_func0 = hwdata_i & `GPF_FUNC0_MASK;
      end
      if (wr_addr_ff == `GPF_FUNC1_ADDR) begin
        nxt_func1 = hwdata_i & `GPF_FUNC1_MASK;
      end
      if (wr_addr_ff == `GPF_FUNC2_ADDR) begin
        nxt_func2 = hwdata_i & `GPF_FUNC2_MASK;
      end
      for (p = 0; p < 3; p = p + 1) begin
        if (wr_addr_ff == port_addr(p[1:0], `GPF_DAT_OFS)) begin
          nxt_dir[p] = hwdata_i[`GPF_DIR_LSB+7:`GPF_DIR_LSB] &
                       port_mask(p[1:0]);
          nxt_out[p] = hwdata_i[`GPF_OUT_LSB+7:`GPF_OUT_LSB] &
                       port_mask(p[1:0]);
        end
        // ones set, zeros leave the bit alone
        if (wr_addr_ff == port_addr(p[1:0], `GPF_SET_OFS)) begin
          nxt_out[p] = out_ff[p] | (hwdata_i[7:0] &
                       port_mask(p[1:0]));
        end
        // ones clear, zeros leave the bit alone
        if (wr_addr_ff == port_addr(p[1:0], `GPF_CLR_OFS)) begin
          nxt_out[p] = out_ff[p] & ~(hwdata_i[7:0] &
                       port_mask(p[1:0]));
        end
      end
    end
    // read mux, unmapped addresses answer zero
    rd_val = 32'h00000000;
    if (haddr_i == `GPF_FUNC0_ADDR) begin
      rd_val = nxt_func0;
    end
    if (haddr_i == `GPF_FUNC1_ADDR) begin
      rd_val = nxt_func1;
    end
    if (haddr_i == `GPF_FUNC2_ADDR) begin
      rd_val = nxt_func2;
    end
    for (p = 0; p < 3; p = p + 1) begin
      if (haddr_i == port_addr(p[1:0], `GPF_DAT_OFS)) begin
        rd_val = {8'h00, nxt_dir[p], nxt_out[p],
                  in_val[p] & port_mask(p[1:0])};
      end
      if ((haddr_i == port_addr(p[1:0], `GPF_SET_OFS)) ||
          (haddr_i == port_addr(p[1:0], `GPF_CLR_OFS))) begin
        rd_val = {24'h000000, nxt_out[p]};
      end
    end
  end

  // ----------------------------------------------------------------
  // register file and ahb data phase
  // ----------------------------------------------------------------
  // all pins reset to plain inputs in gpio mode
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      func0_ff <= `GPF_FUNC0_RST;
      func1_ff <= `GPF_FUNC1_RST;
      func2_ff <= `GPF_FUNC2_RST;
      for (q = 0; q < 3; q = q + 1) begin
        dir_ff[q] <= 8'h00;
        out_ff[q] <= 8'h00;
      end
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 32'h00000000;
      hrdata_o <= 32'h00000000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      func0_ff <= nxt_func0;
      func1_ff <= nxt_func1;
      func2_ff <= nxt_func2;
      for (q = 0; q < 3; q = q + 1) begin
        dir_ff[q] <= nxt_dir[q];
        out_ff[q] <= nxt_out[q];
      end
      // every transfer is taken with no wait state
      wr_pend_ff <= addr_ok & hwrite_i;
      if (addr_ok) begin
        wr_addr_ff <= haddr_i;
      end
      if (addr_ok & ~hwrite_i) begin
        hrdata_o <= rd_val;
      end
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  reg [8:0] nxt_pin_out;
  reg [8:0] nxt_pin_oe_n;
  reg nxt_hva_out;
  reg nxt_hva_oe_n;
  reg nxt_hvb_out;
  reg nxt_hvb_oe_n;
  reg nxt_diag_wr;
  reg nxt_test_out;
  integer i;

  // gpio default first, alternate functions override
  always @* begin
    for (i = 0; i < 5; i = i + 1) begin
      nxt_pin_out[i] = out_ff[0][i];
      nxt_pin_oe_n[i] = ~dir_ff[0][i];
    end
    for (i = 0; i < 2; i = i + 1) begin
      nxt_pin_out[5+i] = out_ff[1][i];
      nxt_pin_oe_n[5+i] = ~dir_ff[1][i];
      nxt_pin_out[7+i] = out_ff[2][i];
      nxt_pin_oe_n[7+i] = ~dir_ff[2][i];
    end
    // spi pins take value and direction from the spi block
    if (func0_ff[`GPF_F0_SS]) begin
      nxt_pin_out[0] = spi_out_i[0];
      nxt_pin_oe_n[0] = spi_oe_n_i[0];
    end
    if (func0_ff[`GPF_F0_SCLK]) begin
      nxt_pin_out[1] = spi_out_i[1];
      nxt_pin_oe_n[1] = spi_oe_n_i[1];
    end
    if (func0_ff[`GPF_F0_MISO]) begin
      nxt_pin_out[2] = spi_out_i[2];
      nxt_pin_oe_n[2] = spi_oe_n_i[2];
    end
    if (func0_ff[`GPF_F0_MOSI]) begin
      nxt_pin_out[3] = spi_out_i[3];
      nxt_pin_oe_n[3] = spi_oe_n_i[3];
    end
    // fixed clock always driven while selected
    if (func0_ff[`GPF_F0_FIXED_CLOCK_OUTPUT]) begin
      nxt_pin_out[4] = fixed_clock_output;
      nxt_pin_oe_n[4] = 1'b0;
    end
    // uart receive: pin becomes input only
    if (func1_ff[`GPF_F1_RXD]) begin
      nxt_pin_out[5] = 1'b0;
      nxt_pin_oe_n[5] = 1'b1;
    end
    // uart transmit drives the pin
    if (func1_ff[`GPF_F1_TXD]) begin
      nxt_pin_out[6] = uart_txd_i;
      nxt_pin_oe_n[6] = 1'b0;
    end
    // internal link lines released unless enabled
    nxt_hva_out = 1'b0;
    nxt_hva_oe_n = 1'b1;
    nxt_hvb_out = 1'b0;
    nxt_hvb_oe_n = 1'b1;
    if (func0_ff[`GPF_F0_HVA]) begin
      nxt_hva_out = out_ff[0][5];
      nxt_hva_oe_n = ~dir_ff[0][5];
    end
    if (func0_ff[`GPF_F0_HVB]) begin
      nxt_hvb_out = out_ff[0][6];
      nxt_hvb_oe_n = ~dir_ff[0][6];
    end
    // diagnostic write line: gpio data or lin transmit
    nxt_diag_wr = func2_ff[`GPF_F2_DIAG_WR] ? lin_txd_i :
                  out_ff[2][5];
    // test data line: gpio data or serial test output
    nxt_test_out = func2_ff[`GPF_F2_STI] ? serial_test_data_i :
                   out_ff[2][6];
  end

  // output flops, frozen while powered down
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      gpio_out_o <= 9'h000;
      gpio_oe_n_o <= 9'h1FF;
      hv_link_line_a_o <= 1'b0;
      hv_link_line_a_oe_n_o <= 1'b1;
      hv_link_line_b_o <= 1'b0;
      hv_link_line_b_oe_n_o <= 1'b1;
      diag_write_line_o <= 1'b0;
      test_data_out_line_o <= 1'b0;
    end else if (!power_down_i) begin
      gpio_out_o <= nxt_pin_out;
      gpio_oe_n_o <= nxt_pin_oe_n;
      hv_link_line_a_o <= nxt_hva_out;
      hv_link_line_a_oe_n_o <= nxt_hva_oe_n;
      hv_link_line_b_o <= nxt_hvb_out;
      hv_link_line_b_oe_n_o <= nxt_hvb_oe_n;
      diag_write_line_o <= nxt_diag_wr;
      test_data_out_line_o <= nxt_test_out;
    end
  end

  // ----------------------------------------------------------------
  // peripheral inputs and external interrupts
  // ----------------------------------------------------------------
  // unlatched level interrupts
  // source holds until software reads
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      spi_in_o <= 4'hF;
      uart_rxd_o <= 1'b1;
      lin_rxd_o <= 1'b1;
      ext_irq_o <= 4'h0;
    end else begin
      spi_in_o <= pin_q[3:0];
      // idle high when the path is not routed
      uart_rxd_o <= func1_ff[`GPF_F1_RXD] ? pin_q[5] : 1'b1;
      lin_rxd_o <= func2_ff[`GPF_F2_DIAG_RD] ? pin_q[11] : 1'b1;
      ext_irq_o <= {pin_q[8], pin_q[7], pin_q[5],
                    pin_q[0]};
    end
  end

endmodule // gpf_top

`default_nettype wire

// ---- test/gpf_board.sv ----
`default_nettype none

// ------------------------------------------------
// board side: pull-ups, drivers, internal lines
// ------------------------------------------------
module gpf_board (
  input wire logic ref_clk_i,
  input wire logic [8:0] out_i,
  input wire logic [8:0] oe_n_i,
  input wire logic [8:0] ext_val_i,
  input wire logic [8:0] ext_en_i,
  input wire logic [1:0] hv_out_i,
  input wire logic [1:0] hv_oe_n_i,
  output logic [8:0] pin_o,
  output logic [1:0] hv_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // released lines wander, no stale value
  logic [1:0] wander_ff = 2'h1;
  always @(posedge ref_clk_i) begin
    wander_ff <= ~wander_ff;
  end
  // chip drive wins, then a board driver, else the pull-up
  assign pin_o = (~oe_n_i & out_i) | (oe_n_i & ext_en_i & ext_val_i)
    | (oe_n_i & ~ext_en_i);
  assign hv_o = (~hv_oe_n_i & hv_out_i) | (hv_oe_n_i & wander_ff);
endmodule // gpf_board

`default_nettype wire

// ---- test/gpf_properties.sv ----
`default_nettype none

// ------------------------------------------------
// port-level checks of the gpio block
// ------------------------------------------------
module gpf_properties (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [8:0] gpio_in_i,
  input wire logic [8:0] gpio_out_o,
  input wire logic [8:0] gpio_oe_n_o,
  input wire logic hv_link_line_a_o,
  input wire logic hv_link_line_a_oe_n_o,
  input wire logic hv_link_line_b_o,
  input wire logic hv_link_line_b_oe_n_o,
  input wire logic [3:0] spi_in_o,
  input wire logic power_down_i,
  input wire logic [3:0] ext_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic [3:0] irq_src;  // interrupt pins 8,7,5,0
  wire logic rd_take;  // read address phase taken
  assign irq_src = {gpio_in_i[8], gpio_in_i[7], gpio_in_i[5], gpio_in_i[0]};
  assign rd_take = hsel_i & htrans_i[1] & ~hwrite_i & hready_i;
  // eight samples outlast the sync chain
  sequence s_irq_steady; $stable(irq_src) [*8]; endsequence
  sequence s_spi_steady; $stable(gpio_in_i[3:0]) [*8]; endsequence
  // freeze lands on the same edge that sees power-down
  sequence s_pd_held; power_down_i [*3]; endsequence
  property p_bus_okay; hreadyout_o && !hresp_o; endproperty
  property p_rst_pins;
    $rose(rst_n_i) |-> gpio_oe_n_o == 9'h1FF && hv_link_line_a_oe_n_o
      && hv_link_line_b_oe_n_o;
  endproperty
  property p_rst_irq;
    $rose(rst_n_i) |-> ext_irq_o == 4'h0 && spi_in_o == 4'hF;
  endproperty
  property p_irq_follow; s_irq_steady |-> ext_irq_o == irq_src; endproperty
  property p_spi_follow;
    s_spi_steady |-> spi_in_o == gpio_in_i[3:0];
  endproperty
  property p_pd_pins;
    s_pd_held |-> $stable(gpio_out_o) && $stable(gpio_oe_n_o);
  endproperty
  property p_pd_hv;
    s_pd_held |-> $stable({hv_link_line_a_o, hv_link_line_a_oe_n_o,
      hv_link_line_b_o, hv_link_line_b_oe_n_o});
  endproperty
  property p_rd_hold; !rd_take |=> $stable(hrdata_o); endproperty
  a_bus_okay: assert property (p_bus_okay)
    else $error("bus answer not zero-wait okay");
  a_rst_pins: assert property (p_rst_pins)
    else $error("pins not released after reset");
  a_rst_irq: assert property (p_rst_irq)
    else $error("sync outputs wrong after reset");
  a_irq_follow: assert property (p_irq_follow)
    else $error("interrupt does not follow pin level");
  a_spi_follow: assert property (p_spi_follow)
    else $error("spi input does not follow pins");
  a_pd_pins: assert property (p_pd_pins)
    else $error("pin moved in power-down");
  a_pd_hv: assert property (p_pd_hv)
    else $error("internal line moved in power-down");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without read");
endmodule // gpf_properties

bind gpf_top gpf_properties u_props (.*);

`default_nettype wire

// ---- test/testbench.sv ----
`default_nettype none
`include "gpf_defines.vh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel_i = 1'b0, hwrite_i = 1'b0, power_down_i = 1'b0;
  logic [1:0] htrans_i = 2'h0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0;
  logic [3:0] spi_out_i = 4'h0, spi_oe_n_i = 4'hF;
  logic uart_txd_i = 1'b1, lin_txd_i = 1'b1;
  logic serial_test_data_i = 1'b0, diag_readback_line_i = 1'b1;
  logic [8:0] ext_val = 9'h0, ext_en = 9'h0;  // board drivers
  wire logic [31:0] hrdata_o;
  wire logic hreadyout_o, hresp_o, diag_write_line_o, test_data_out_line_o;
  wire logic uart_rxd_o, lin_rxd_o, hv_link_line_a_i, hv_link_line_b_i;
  wire logic hv_link_line_a_o, hv_link_line_a_oe_n_o;
  wire logic hv_link_line_b_o, hv_link_line_b_oe_n_o;
  wire logic [8:0] gpio_in_i, gpio_out_o, gpio_oe_n_o;
  wire logic [3:0] spi_in_o, ext_irq_o;
  // ------------------------------------------------
  // reference model
  // ------------------------------------------------
  logic [31:0] fn [3];  // function selects
  logic [31:0] dt [3];  // direction [23:16], value [15:8]
  logic [31:0] fmask [3] = '{`GPF_FUNC0_MASK, `GPF_FUNC1_MASK,
    `GPF_FUNC2_MASK};
  logic [7:0] pmask [3] = '{`GPF_P0_MASK, `GPF_P1_MASK, `GPF_P2_MASK};
  int lo [3] = '{0, 5, 7};  // first pin of each port
  int ipin [4] = '{0, 5, 7, 8};  // interrupt pins
  logic [31:0] wm [3] = '{32'h1F, 32'h3, 32'h3};
  logic [8:0] lv;  // expected pin levels
  logic [31:0] lfsr = 32'hCD5B;
  int mismatches = 0, compares = 0, cyc = 0;

  always #20 ref_clk_i = ~ref_clk_i;

  gpf_top dut_u (.*, .hsize_i(3'h2), .hready_i(hreadyout_o));
  gpf_board board_u (
    .ref_clk_i, .out_i(gpio_out_o), .oe_n_i(gpio_oe_n_o),
    .ext_val_i(ext_val), .ext_en_i(ext_en),
    .hv_out_i({hv_link_line_b_o, hv_link_line_a_o}),
    .hv_oe_n_i({hv_link_line_b_oe_n_o, hv_link_line_a_oe_n_o}),
    .pin_o(gpio_in_i), .hv_o({hv_link_line_b_i, hv_link_line_a_i})
  );

  // hang guard
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      tally_and_finish();
    end
  end

  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic mreset();
    fn = '{`GPF_FUNC0_RST, `GPF_FUNC1_RST, `GPF_FUNC2_RST};
    dt = '{32'h0, 32'h0, 32'h0};
  endtask

  // single transfer, waits on hready
  task automatic bus(input logic w, input logic [31:0] a,
    input logic [31:0] d, output logic [31:0] r);
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= 2'h2;
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    r = hrdata_o;
  endtask

  // kind 0 function, 1 data, 2 set, 3 clear
  function automatic logic [31:0] adr(input int p, input int k);
    if (k == 0)
      return `GPF_FUNC0_ADDR + 32'(4 * p);
    return `GPF_DAT0_ADDR + `GPF_PORT_STRIDE * 32'(p) + 32'(4 * (k - 1));
  endfunction

  task automatic wr(input int p, input int k, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, adr(p, k), d, r);
    case (k)
      0: fn[p] = d & fmask[p];  // reserved bits not kept
      1: dt[p] = d & {8'h0, pmask[p], pmask[p], 8'h0};
      2: dt[p] = dt[p] | {16'h0, d[7:0] & pmask[p], 8'h0};
      default: dt[p] = dt[p] & ~{16'h0, d[7:0], 8'h0};
    endcase
  endtask

  task automatic rc(input int p, input int k, output logic [31:0] r);
    bus(1'b0, adr(p, k), 32'h0, r);
    if (k == 0)
      chk(r, fn[p]);
    else
      chk(r & 32'h00FFFF00, dt[p]);
  endtask

  // expected pin drive
  task automatic pins_chk();
    logic [8:0] en, eo;
    int p;
    for (int i = 0; i < 9; i++) begin
      p = i < 5 ? 0 : (i < 7 ? 1 : 2);
      en[i] = ~dt[p][16 + i - lo[p]];
      eo[i] = dt[p][8 + i - lo[p]];
      if (i < 4 && fn[0][4 * i]) begin  // spi owns pins 0-3
        en[i] = spi_oe_n_i[i];
        eo[i] = spi_out_i[i];
      end
      if (i == 5 && fn[1][0])
        en[i] = 1'b1;  // receive pin stays an input
      if (i == 6 && fn[1][4]) begin
        en[i] = 1'b0;
        eo[i] = uart_txd_i;
      end
    end
    lv = en | eo;
    chk(32'(gpio_oe_n_o), 32'(en));
    chk(32'(gpio_out_o & ~en), 32'(eo & ~en));
    chk(32'(hv_link_line_a_oe_n_o), 32'(!(fn[0][20] & dt[0][21])));
    chk(32'(hv_link_line_b_oe_n_o), 32'(!(fn[0][24] & dt[0][22])));
    chk(32'(diag_write_line_o), 32'(fn[2][20] ? lin_txd_i : dt[2][13]));
    chk(32'(test_data_out_line_o),
      32'(fn[2][24] ? serial_test_data_i : dt[2][14]));
    chk(32'(uart_rxd_o), 32'(fn[1][0] ? lv[5] : 1'b1));
    chk(32'(lin_rxd_o), 32'(fn[2][16] ? diag_readback_line_i : 1'b1));
  endtask

  task automatic rises(input int n, output int k);
    logic last;
    k = 0;
    last = gpio_out_o[4];
    repeat (n) begin
      @(negedge ref_clk_i);
      if (gpio_out_o[4] && !last)
        k++;
      last = gpio_out_o[4];
    end
  endtask

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    logic [31:0] r;
    int k;
    mreset();
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    pins_chk();  // plain gpio after reset
    for (int p = 0; p < 3; p++) begin
      rc(p, 0, r);
      wr(p, 0, 32'hFFFFFFFF);  // reserved bits read back zero
      rc(p, 0, r);
    end
    bus(1'b1, 32'hFFFF0D0C, 32'hFFFFFFFF, r);  // unmapped hole
    bus(1'b0, 32'hFFFF0D0C, 32'h0, r);
    chk(r, 32'h0);
    for (int n = 0; n < 24; n++) begin
      r = rnd();
      spi_out_i <= r[3:0];
      spi_oe_n_i <= r[7:4];
      uart_txd_i <= r[8];
      lin_txd_i <= r[9];
      serial_test_data_i <= r[10];
      diag_readback_line_i <= r[11];
      wr(0, 0, 32'h10000000 | (rnd() & 32'h01101111));
      wr(1, 0, rnd() & 32'h11);
      wr(2, 0, rnd() & 32'h01110000);
      for (int p = 0; p < 3; p++) begin
        wr(p, 1, rnd());
        wr(p, 2 + n % 2, rnd());
      end
      repeat (8) @(posedge ref_clk_i);
      pins_chk();
      for (int p = 0; p < 3; p++) begin
        rc(p, 0, r);
        rc(p, 1, r);
        chk(32'(r[4:0]) & wm[p], 32'(lv >> lo[p]) & wm[p]);
      end
    end
    for (int p = 0; p < 3; p++)
      wr(p, 1, 32'h0);
    wr(0, 0, `GPF_FUNC0_RST);
    wr(1, 0, 32'h0);
    ext_en <= 9'h1A1;
    for (int j = 0; j < 5; j++) begin
      ext_val <= j < 4 ? 9'(1 << ipin[j]) : 9'h1A1;  // held long
      repeat (10) @(posedge ref_clk_i);
      chk(32'(ext_irq_o), j < 4 ? 32'(1 << j) : 32'hF);
    end
    ext_en <= 9'h0;
    wr(0, 0, 32'h10010000);
    repeat (20) @(posedge ref_clk_i);
    rises(250, k);
    chk(32'(k == 25 || k == 26), 32'h1);
    chk(32'(gpio_oe_n_o[4]), 32'h0);
    @(posedge ref_clk_i);
    power_down_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    r = 32'({gpio_oe_n_o, gpio_out_o});
    rises(50, k);
    chk(32'(k), 32'h0);
    @(posedge ref_clk_i);
    wr(0, 0, `GPF_FUNC0_RST);
    wr(0, 1, rnd());
    wr(2, 1, rnd());
    repeat (8) @(posedge ref_clk_i);
    chk(32'({gpio_oe_n_o, gpio_out_o}), r);
    power_down_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    pins_chk();  // registers updated while frozen
    rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    mreset();
    @(posedge ref_clk_i);
    rc(0, 0, r);
    tally_and_finish();
  end
endmodule // testbench

`default_nettype wire
